// ==== verilog/lsm_display_control.sv ====
// display screen memory control: registers, scroll, freeze, power gating
// Function
// (R01) auto scroll steps screens only with scroll enable and blink enable set
// (R02) both blink mode bits set makes scroll rate follow blink rate bits
// (R03) auto scrolling keeps running in all power modes
// (R04) memory is four banks of fifteen bytes, bank chosen by two bits
// (R05) low nibble drives even segment, high nibble odd, bit per common
// (R06) memory contents kept in deep power saving mode
// (R07) pointer write picks screen and byte and starts a transfer
// (R08) freeze bit holds shown data; software sets it while updating
// (R09) software loads data register before pointer write, matching screen
// (R10) pointer write with top bit set stores data byte into memory
// (R11) pointer write with top bit clear loads memory byte into data reg
// (R12) voltage select resets to pump; one selects external ladder
// (R13) pump selected and display disabled turns voltage generation off
// (R14) six bit bias level picks one of 64 pump bias voltages
// (R15) external ladder: no on-chip generation, bias level ignored
// (R16) in deep sleep display on only if sleep-off clear and enable set
// (R17) display works in deep sleep only with reference enable set
// (R18) display off keeps configuration and all screen memory
// (R19) pointer: direction bit 7, reserved 6, screen 5:4, address 3:0
// (R20) memory clear bit or power-on reset zeroes all display memory
// (R21) without freeze the selected screen bits choose the shown screen; while auto scroll is active the scroll counter chooses instead
// (R22) pointer read completes at once, data readable next instruction
// (R23) each blink period advances to next bank, wrapping after last
`timescale 1ns/1ps
module lsm_display_control (
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic [7:0] sfr_addr_in,
   input wire logic sfr_write_in,
   input wire logic [7:0] sfr_wdata_in,
   output logic [7:0] sfr_rdata_out,
   input wire logic blink_tick_in,
   input wire logic deep_power_saving_mode_in,
   input wire logic reference_enable_in,
   output logic display_on_out,
   output logic pump_enable_out,
   output logic external_ladder_select_out,
   output logic [5:0] bias_level_out,
   output logic blink_enable_out,
   output logic [1:0] blink_mode_select_out,
   output logic [1:0] blink_rate_select_out,
   output logic scroll_active_out,
   output logic [1:0] shown_screen_out,
   output logic [8*lsm_pkg::BANK_BYTES-1:0] segment_data_out
);
   logic [7:0] display_config;
   logic [7:0] display_clock_blink;
   logic [7:0] display_voltage_config;
   logic [7:0] display_memory_pointer;
   logic [7:0] display_memory_data;
   logic [7:0] display_screen_config;
   logic [1:0] scroll_screen;
   logic [1:0] frozen_screen;
   logic [8*lsm_pkg::BANK_BYTES-1:0] frozen_bytes;
   logic [7:0] next_display_config;
   logic [7:0] next_display_clock_blink;
   logic [7:0] next_display_voltage_config;
   logic [7:0] next_display_memory_pointer;
   logic [7:0] next_display_memory_data;
   logic [7:0] next_display_screen_config;
   logic [1:0] next_scroll_screen;
   logic [1:0] next_frozen_screen;
   logic [8*lsm_pkg::BANK_BYTES-1:0] next_frozen_bytes;
   logic [1:0] ref_sync;
   logic [1:0] psm_sync;
   logic [1:0] tick_sync;
   logic tick_last;
   logic tick_rise;
   logic ptr_write;
   logic mem_write;
   logic mem_clear;
   logic freeze;
   logic scroll_on;
   logic [1:0] live_screen;
   logic [1:0] ptr_bank;
   logic [3:0] ptr_addr;
   logic [7:0] mem_rdata;
   logic [8*lsm_pkg::BANK_BYTES-1:0] live_bytes;

   // power and tick inputs come from other domains
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ref_sync <= 2'h0;
         psm_sync <= 2'h0;
         tick_sync <= 2'h0;
         tick_last <= 1'h0;
      end else begin
         ref_sync <= {ref_sync[0], reference_enable_in};
         psm_sync <= {psm_sync[0], deep_power_saving_mode_in};
         tick_sync <= {tick_sync[0], blink_tick_in};
         tick_last <= tick_sync[1];
      end
   end
   assign tick_rise = tick_sync[1] & ~tick_last;

   assign ptr_write = sfr_write_in &&
      sfr_addr_in == lsm_pkg::ADDR_DISPLAY_MEMORY_POINTER; // (R07)
   assign ptr_bank = sfr_wdata_in[lsm_pkg::PTR_SCREEN_HI:
                                  lsm_pkg::PTR_SCREEN_LO]; // (R19)
   assign ptr_addr = sfr_wdata_in[lsm_pkg::PTR_ADDR_HI:
                                  lsm_pkg::PTR_ADDR_LO]; // (R19)
   assign mem_write = ptr_write &&
      sfr_wdata_in[lsm_pkg::PTR_WRITE_BIT]; // (R10)
   // clear bit self-clears; clearing is one edge long
   assign mem_clear = display_config[lsm_pkg::CFG_MEMORY_CLEAR_BIT]; // (R20)
   assign freeze = display_screen_config[lsm_pkg::SCR_FREEZE_BIT];
   // scroll ignores power mode on purpose
   assign scroll_on =
      display_screen_config[lsm_pkg::SCR_AUTO_SCROLL_BIT] &&
      display_config[lsm_pkg::CFG_BLINK_ENABLE_BIT]; // (R01) (R03)
   assign live_screen = scroll_on ? scroll_screen :
      display_screen_config[lsm_pkg::SCR_SELECT_HI:
                            lsm_pkg::SCR_SELECT_LO]; // (R21)

   lsm_screen_memory lsm_screen_memory_inst (
      .core_clk_in(core_clk_in),
      .rst_n_in(rst_n_in),
      .clear_in(mem_clear),
      .write_in(mem_write),
      .cpu_bank_in(ptr_bank),
      .cpu_addr_in(ptr_addr),
      .cpu_data_in(display_memory_data),
      .cpu_data_out(mem_rdata),
      .show_bank_in(live_screen),
      .show_bytes_out(live_bytes)
   ); // (R04)

   always_comb begin
      next_display_config = display_config;
      next_display_clock_blink = display_clock_blink;
      next_display_voltage_config = display_voltage_config;
      next_display_memory_pointer = display_memory_pointer;
      next_display_memory_data = display_memory_data;
      next_display_screen_config = display_screen_config;
      next_display_config[lsm_pkg::CFG_MEMORY_CLEAR_BIT] = 1'b0;
      if (sfr_write_in) begin
         case (sfr_addr_in)
            lsm_pkg::ADDR_DISPLAY_CONFIG: begin
               next_display_config = sfr_wdata_in;
            end
            lsm_pkg::ADDR_DISPLAY_CLOCK_BLINK: begin
               next_display_clock_blink = sfr_wdata_in;
            end
            lsm_pkg::ADDR_DISPLAY_VOLTAGE_CONFIG: begin
               next_display_voltage_config = sfr_wdata_in; // (R12)
            end
            lsm_pkg::ADDR_DISPLAY_MEMORY_POINTER: begin
               next_display_memory_pointer =
                  sfr_wdata_in & lsm_pkg::PTR_WRITE_MASK; // (R19)
            end
            lsm_pkg::ADDR_DISPLAY_MEMORY_DATA: begin
               next_display_memory_data = sfr_wdata_in;
            end
            lsm_pkg::ADDR_DISPLAY_SCREEN_CONFIG: begin
               next_display_screen_config = sfr_wdata_in;
            end
            default: begin
               next_display_config[lsm_pkg::CFG_MEMORY_CLEAR_BIT] = 1'b0;
            end
         endcase
      end
      // read lands in data register on the pointer write edge
      if (ptr_write && !sfr_wdata_in[lsm_pkg::PTR_WRITE_BIT]) begin
         next_display_memory_data = mem_rdata; // (R11) (R22)
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         display_config <= lsm_pkg::RESET_BYTE;
         display_clock_blink <= lsm_pkg::RESET_BYTE;
         display_voltage_config <= lsm_pkg::RESET_BYTE; // (R12)
         display_memory_pointer <= lsm_pkg::RESET_BYTE;
         display_memory_data <= lsm_pkg::RESET_BYTE;
         display_screen_config <= lsm_pkg::RESET_BYTE;
      end else begin
         display_config <= next_display_config;
         display_clock_blink <= next_display_clock_blink;
         display_voltage_config <= next_display_voltage_config;
         display_memory_pointer <= next_display_memory_pointer;
         display_memory_data <= next_display_memory_data;
         display_screen_config <= next_display_screen_config;
      end
   end

   // scroll and freeze state
   always_comb begin
      next_scroll_screen = scroll_screen;
      next_frozen_screen = frozen_screen;
      next_frozen_bytes = frozen_bytes;
      if (scroll_on && tick_rise) begin
         next_scroll_screen = scroll_screen + 2'h1; // (R23)
      end
      // snapshot follows live view until freeze is raised
      if (!freeze) begin
         next_frozen_screen = live_screen;
         next_frozen_bytes = live_bytes; // (R08)
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         scroll_screen <= 2'h0;
         frozen_screen <= 2'h0;
         frozen_bytes <= '0;
      end else begin
         scroll_screen <= next_scroll_screen;
         frozen_screen <= next_frozen_screen;
         frozen_bytes <= next_frozen_bytes;
      end
   end

   // outputs: freeze keeps previous picture on the glass
   always_comb begin
      segment_data_out = freeze ? frozen_bytes : live_bytes; // (R08) (R05)
      shown_screen_out = freeze ? frozen_screen : live_screen;
      scroll_active_out = scroll_on;
      blink_enable_out = display_config[lsm_pkg::CFG_BLINK_ENABLE_BIT];
      blink_mode_select_out = display_clock_blink[lsm_pkg::BLINK_MODE_HI:
                                                  lsm_pkg::BLINK_MODE_LO];
      // rate bits only count when both mode bits are set
      if (blink_mode_select_out == 2'h3) begin
         blink_rate_select_out = display_clock_blink[lsm_pkg::BLINK_RATE_HI:
                                                     lsm_pkg::BLINK_RATE_LO];
      end else begin
         blink_rate_select_out = 2'h0; // (R02)
      end
      external_ladder_select_out =
         display_voltage_config[lsm_pkg::VOLT_EXT_LADDER_BIT]; // (R12)
      // display off touches no register nor memory
      if (psm_sync[1]) begin
         display_on_out = display_config[lsm_pkg::CFG_DISPLAY_ENABLE_BIT] &&
            !display_config[lsm_pkg::CFG_SLEEP_DISPLAY_OFF_BIT] &&
            ref_sync[1]; // (R16) (R17) (R18)
      end else begin
         display_on_out = display_config[lsm_pkg::CFG_DISPLAY_ENABLE_BIT];
      end
      pump_enable_out = display_on_out && !external_ladder_select_out; // (R13)
      if (external_ladder_select_out) begin
         bias_level_out = 6'h00; // (R15)
      end else begin
         bias_level_out = display_voltage_config[lsm_pkg::BIAS_HI:
                                                 lsm_pkg::BIAS_LO]; // (R14)
      end
   end

   // register read mux, unmapped reads zero
   always_comb begin
      case (sfr_addr_in)
         lsm_pkg::ADDR_DISPLAY_CONFIG: sfr_rdata_out = display_config;
         lsm_pkg::ADDR_DISPLAY_CLOCK_BLINK: begin
            sfr_rdata_out = display_clock_blink;
         end
         lsm_pkg::ADDR_DISPLAY_VOLTAGE_CONFIG: begin
            sfr_rdata_out = display_voltage_config;
         end
         lsm_pkg::ADDR_DISPLAY_MEMORY_POINTER: begin
            sfr_rdata_out = display_memory_pointer;
         end
         lsm_pkg::ADDR_DISPLAY_MEMORY_DATA: begin
            sfr_rdata_out = display_memory_data;
         end
         lsm_pkg::ADDR_DISPLAY_SCREEN_CONFIG: begin
            sfr_rdata_out = display_screen_config;
         end
         default: sfr_rdata_out = lsm_pkg::RESET_BYTE;
      endcase
   end
endmodule

// ==== pkg/lsm_pkg.sv ====
// constants for the display screen memory control block
package lsm_pkg;
   localparam logic [7:0] ADDR_DISPLAY_CONFIG = 8'h95;
   localparam logic [7:0] ADDR_DISPLAY_CLOCK_BLINK = 8'h96;
   localparam logic [7:0] ADDR_DISPLAY_VOLTAGE_CONFIG = 8'h9C;
   localparam logic [7:0] ADDR_DISPLAY_MEMORY_POINTER = 8'hAC;
   localparam logic [7:0] ADDR_DISPLAY_MEMORY_DATA = 8'hAE;
   localparam logic [7:0] ADDR_DISPLAY_SCREEN_CONFIG = 8'hB1;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam int NUM_BANKS = 4;
   localparam int BANK_BYTES = 15;
   localparam logic [3:0] LAST_BYTE_ADDR = 4'hE;
   // display_config fields
   localparam int CFG_DISPLAY_ENABLE_BIT = 7;
   localparam int CFG_MEMORY_CLEAR_BIT = 6;
   localparam int CFG_BLINK_ENABLE_BIT = 5;
   localparam int CFG_SLEEP_DISPLAY_OFF_BIT = 4;
   // display_clock_blink fields
   localparam int BLINK_MODE_HI = 7;
   localparam int BLINK_MODE_LO = 6;
   localparam int BLINK_RATE_HI = 5;
   localparam int BLINK_RATE_LO = 4;
   // display_voltage_config fields
   localparam int VOLT_EXT_LADDER_BIT = 6;
   localparam int BIAS_HI = 5;
   localparam int BIAS_LO = 0;
   // display_screen_config fields
   localparam int SCR_AUTO_SCROLL_BIT = 7;
   localparam int SCR_SELECT_HI = 3;
   localparam int SCR_SELECT_LO = 2;
   localparam int SCR_FREEZE_BIT = 0;
   // display_memory_pointer fields, plus REF_ENABLE_BIT, which is unused
   localparam int PTR_WRITE_BIT = 7;
   localparam int PTR_SCREEN_HI = 5;
   localparam int PTR_SCREEN_LO = 4;
   localparam int PTR_ADDR_HI = 3;
   localparam int PTR_ADDR_LO = 0;
   localparam logic [7:0] PTR_WRITE_MASK = 8'hBF;
   localparam int REF_ENABLE_BIT = 3;
endpackage

// ==== verilog/lsm_screen_memory.sv ====
// four banks of fifteen display bytes with clear, one cpu port and a whole-bank show port
`timescale 1ns/1ps
module lsm_screen_memory (
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic clear_in,
   input wire logic write_in,
   input wire logic [1:0] cpu_bank_in,
   input wire logic [3:0] cpu_addr_in,
   input wire logic [7:0] cpu_data_in,
   output logic [7:0] cpu_data_out,
   input wire logic [1:0] show_bank_in,
   output logic [8*lsm_pkg::BANK_BYTES-1:0] show_bytes_out
);
   logic [7:0] mem [lsm_pkg::NUM_BANKS][lsm_pkg::BANK_BYTES];
   logic [7:0] next_mem [lsm_pkg::NUM_BANKS][lsm_pkg::BANK_BYTES];
   logic [7:0] rd_byte;

   // combinational read so a pointer write can load data in the same edge
   always_comb begin
      if (cpu_addr_in <= lsm_pkg::LAST_BYTE_ADDR) begin
         rd_byte = mem[cpu_bank_in][cpu_addr_in];
      end else begin
         rd_byte = lsm_pkg::RESET_BYTE;
      end
   end
   assign cpu_data_out = rd_byte;

   always_comb begin
      next_mem = mem;
      if (clear_in) begin
         for (int b = 0; b < lsm_pkg::NUM_BANKS; b++) begin
            for (int i = 0; i < lsm_pkg::BANK_BYTES; i++) begin
               next_mem[b][i] = lsm_pkg::RESET_BYTE; // (R20)
            end
         end
      end else if (write_in && cpu_addr_in <= lsm_pkg::LAST_BYTE_ADDR) begin
         next_mem[cpu_bank_in][cpu_addr_in] = cpu_data_in; // (R10)
      end
   end

   // no power-state input: contents survive sleep and display off
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         for (int b = 0; b < lsm_pkg::NUM_BANKS; b++) begin
            for (int i = 0; i < lsm_pkg::BANK_BYTES; i++) begin
               mem[b][i] <= lsm_pkg::RESET_BYTE; // (R20)
            end
         end
      end else begin
         mem <= next_mem; // (R06)
      end
   end

   // low nibble even segment, high nibble odd segment
   genvar g;
   generate
      for (g = 0; g < lsm_pkg::BANK_BYTES; g++) begin : g_show
         assign show_bytes_out[8*g +: 8] = mem[show_bank_in][g]; // (R05)
      end
   endgenerate
endmodule

// ==== verif/lsm_display_control_chk.sv ====
// port assertions for the display screen memory control block
`timescale 1ns/1ps
module lsm_display_control_chk (
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic [7:0] sfr_addr_in,
   input wire logic sfr_write_in,
   input wire logic [7:0] sfr_wdata_in,
   input wire logic [7:0] sfr_rdata_out,
   input wire logic deep_power_saving_mode_in,
   input wire logic reference_enable_in,
   input wire logic display_on_out,
   input wire logic pump_enable_out,
   input wire logic external_ladder_select_out,
   input wire logic [5:0] bias_level_out,
   input wire logic blink_enable_out,
   input wire logic [1:0] blink_mode_select_out,
   input wire logic [1:0] blink_rate_select_out,
   input wire logic scroll_active_out
);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);
   logic vwr;
   logic bwr;
   assign vwr = sfr_write_in && (sfr_addr_in == 8'h9C);
   assign bwr = sfr_write_in && (sfr_addr_in == 8'h96);
   a_pump_follows_on: assert property (
      pump_enable_out == (display_on_out && !external_ladder_select_out))
      else $error("pump enable wrong");
   a_ladder_no_bias: assert property (
      external_ladder_select_out
      |-> bias_level_out == 6'h00 && !pump_enable_out)
      else $error("bias active with ladder");
   a_ladder_bit_taken: assert property (
      vwr |=> external_ladder_select_out == $past(sfr_wdata_in[6]))
      else $error("ladder select not taken");
   a_bias_level_taken: assert property (
      vwr && !sfr_wdata_in[6] |=> bias_level_out == $past(sfr_wdata_in[5:0]))
      else $error("bias level not taken");
   a_scroll_needs_blink: assert property (
      !blink_enable_out |-> !scroll_active_out)
      else $error("scroll without blink");
   a_rate_needs_mode: assert property (
      blink_mode_select_out != 2'h3 |-> blink_rate_select_out == 2'h0)
      else $error("rate without mode");
   a_rate_taken: assert property (
      bwr && sfr_wdata_in[7:6] == 2'h3
      |=> blink_rate_select_out == $past(sfr_wdata_in[5:4]))
      else $error("rate not taken");
   a_sleep_needs_ref: assert property (
      (deep_power_saving_mode_in && !reference_enable_in) [*4]
      |-> !display_on_out)
      else $error("display on in sleep without reference");
   a_enable_gates_on: assert property (
      sfr_addr_in == 8'h95 && !sfr_rdata_out[7] |-> !display_on_out)
      else $error("display on while disabled");
   a_ptr_reserved_zero: assert property (
      sfr_addr_in == 8'hAC |-> !sfr_rdata_out[6])
      else $error("pointer reserved bit set");
endmodule
bind lsm_display_control lsm_display_control_chk lsm_chk_inst (.*);

// ==== verif/lsm_glass_model.sv ====
// segment glass model: lit state per segment line and common line
`timescale 1ns/1ps
module lsm_glass_model (
   input wire logic [119:0] segment_data_in,
   input wire logic display_on_in,
   output logic [119:0] lit_out
);
   // index is segment line times four plus common line
   always_comb begin
      for (int i = 0; i < 15; i++) begin
         for (int c = 0; c < 4; c++) begin
            lit_out[8*i+c] = display_on_in && segment_data_in[8*i+c];
            lit_out[8*i+4+c] = display_on_in && segment_data_in[8*i+4+c];
         end
      end
   end
endmodule

// ==== verif/tb.sv ====
// self-checking bench for the display screen memory control block
`timescale 1ns/1ps
module tb;
   typedef struct {logic [1:0] k; logic [119:0] v;} lsm_note_type;
   logic core_clk_in, rst_n_in, sfr_write_in, blink_tick_in;
   logic deep_power_saving_mode_in, reference_enable_in;
   logic [7:0] sfr_addr_in, sfr_wdata_in, sfr_rdata_out, d;
   logic display_on_out, pump_enable_out, external_ladder_select_out;
   logic blink_enable_out, scroll_active_out, e_on, e_lad, e_scr, e_blk;
   logic [5:0] bias_level_out, e_bias;
   logic [1:0] blink_mode_select_out, blink_rate_select_out, e_rate, e_mode;
   logic [1:0] shown_screen_out;
   logic [119:0] segment_data_out, lit, old;
   logic [7:0] mem [4][15];
   logic [7:0] adr [7] = '{8'h95, 8'h96, 8'h9C, 8'hAC, 8'hAE, 8'hB1, 8'h00};
   lsm_note_type notes[$];
   lsm_note_type cur;
   int fails = 0;
   int checked = 0;
   int seed = 32'h3F3BEE55;
   lsm_display_control lsm_display_control_inst (.*);
   lsm_glass_model lsm_glass_model_inst (
      .segment_data_in(segment_data_out),
      .display_on_in(display_on_out),
      .lit_out(lit)
   );
   initial begin
      core_clk_in = 1'b0;
      forever #5 core_clk_in = ~core_clk_in;
   end
   task automatic check(input string n, input logic [119:0] s,
         input logic [119:0] e);
      checked++;
      if (s !== e) begin
         fails++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   // outputs sampled at the rising edge, a full half cycle after drive
   always @(posedge core_clk_in) begin
      while (notes.size() > 0) begin
         cur = notes.pop_front();
         case (cur.k)
            2'h0: check("read data", {112'h0, sfr_rdata_out}, cur.v);
            2'h1: check("glass", lit, cur.v);
            2'h2: check("shown screen", {118'h0, shown_screen_out}, cur.v);
            default: check("drive", {105'h0, blink_enable_out,
               blink_mode_select_out, display_on_out, pump_enable_out,
               external_ladder_select_out, bias_level_out,
               blink_rate_select_out, scroll_active_out}, cur.v);
         endcase
      end
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      sfr_addr_in = a;
      sfr_wdata_in = v;
      sfr_write_in = 1'b1;
      @(negedge core_clk_in);
   endtask
   // one settling cycle first, so registered outputs have landed
   task automatic note(input logic [1:0] k, input logic [119:0] v,
         input logic [7:0] a);
      sfr_write_in = 1'b0;
      sfr_addr_in = a;
      @(negedge core_clk_in);
      notes.push_back('{k, v});
      @(negedge core_clk_in);
   endtask
   task automatic idle(input int n);
      sfr_write_in = 1'b0;
      repeat (n) @(negedge core_clk_in);
   endtask
   function automatic logic [119:0] drv();
      return {105'h0, e_blk, e_mode, e_on, e_on && !e_lad, e_lad,
         e_lad ? 6'h00 : e_bias, e_rate, e_scr};
   endfunction
   function automatic logic [119:0] glass(input int b);
      logic [119:0] r;
      for (int i = 0; i < 15; i++) begin
         for (int c = 0; c < 4; c++) begin
            r[8*i+c] = mem[b][i][c];
            r[8*i+4+c] = mem[b][i][c+4];
         end
      end
      return r;
   endfunction
   task automatic store(input int b, input int a, input logic [7:0] v);
      wr(8'hAE, v);
      wr(8'hAC, {2'b10, b[1:0], a[3:0]});
      mem[b][a] = v;
   endtask
   task automatic fetch(input int b, input int a);
      wr(8'hAC, {2'b00, b[1:0], a[3:0]});
      note(2'h0, {112'h0, mem[b][a]}, 8'hAE);
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      #100000;
      fails++;
      finish_test();
   end
   initial begin
      rst_n_in = 1'b0;
      sfr_write_in = 1'b0;
      sfr_addr_in = 8'h00;
      sfr_wdata_in = 8'h00;
      blink_tick_in = 1'b0;
      deep_power_saving_mode_in = 1'b0;
      reference_enable_in = 1'b0;
      {e_on, e_lad, e_scr, e_blk, e_bias, e_rate, e_mode} = 14'h0000;
      foreach (mem[b, a]) mem[b][a] = 8'h00;
      repeat (16) @(negedge core_clk_in);
      rst_n_in = 1'b1;
      @(negedge core_clk_in);
      foreach (adr[i]) note(2'h0, 120'h0, adr[i]);
      note(2'h3, drv(), 8'h00);
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         d = $random(seed);
         {e_lad, e_on, e_bias} = {i[1:0], d[5:0]};
         wr(8'h95, {i[0], 7'h00});
         wr(8'h9C, {1'b0, i[1], d[5:0]});
         note(2'h0, {112'h0, 1'b0, i[1], d[5:0]}, 8'h9C);
         note(2'h3, drv(), 8'h00);
      end
      for (int m = 0; m < 4; m++) begin
         d = $random(seed);
         e_rate = (m == 3) ? d[5:4] : 2'h0;
         e_mode = m[1:0];
         wr(8'h96, {m[1:0], d[5:4], 4'h0});
         note(2'h3, drv(), 8'h96);
      end
      $display("test voltage and blink done");
      wr(8'h95, 8'h80);
      wr(8'hB1, 8'h01);
      for (int b = 0; b < 4; b++) begin
         for (int a = 0; a < 15; a += 7) begin
            d = $random(seed);
            store(b, a, d);
            fetch(b, a);
         end
      end
      // byte address 15 is refused: write dropped, read gives zero
      wr(8'hAE, 8'hFF);
      wr(8'hAC, 8'h8F);
      wr(8'hAC, 8'h0F);
      note(2'h0, 120'h0, 8'hAE);
      wr(8'hAC, 8'h5E);
      note(2'h0, 120'h1E, 8'hAC);
      note(2'h0, {112'h0, mem[1][14]}, 8'hAE);
      note(2'h1, 120'h0, 8'h00);
      wr(8'hB1, 8'h08);
      note(2'h2, 120'h2, 8'h00);
      note(2'h1, glass(2), 8'h00);
      old = glass(2);
      wr(8'hB1, 8'h09);
      store(2, 7, ~mem[2][7]);
      note(2'h1, old, 8'h00);
      wr(8'hB1, 8'h08);
      note(2'h1, glass(2), 8'h00);
      $display("test memory done");
      deep_power_saving_mode_in = 1'b1;
      e_on = 1'b0;
      idle(4);
      note(2'h3, drv(), 8'h00);
      reference_enable_in = 1'b1;
      e_on = 1'b1;
      idle(4);
      note(2'h3, drv(), 8'h00);
      wr(8'h95, 8'h90);
      e_on = 1'b0;
      note(2'h3, drv(), 8'h00);
      note(2'h1, 120'h0, 8'h00);
      wr(8'h95, 8'h80);
      e_on = 1'b1;
      note(2'h1, glass(2), 8'h00);
      $display("test sleep done");
      wr(8'h95, 8'hA0);
      wr(8'hB1, 8'h80);
      {e_scr, e_blk} = 2'h3;
      note(2'h3, drv(), 8'h00);
      for (int t = 1; t < 6; t++) begin
         blink_tick_in = 1'b1;
         idle(2);
         blink_tick_in = 1'b0;
         idle(4);
         note(2'h2, 120'(t % 4), 8'h00);
      end
      wr(8'h95, 8'h80);
      {e_scr, e_blk} = 2'h0;
      blink_tick_in = 1'b1;
      idle(6);
      note(2'h2, 120'h0, 8'h00);
      blink_tick_in = 1'b0;
      note(2'h3, drv(), 8'h00);
      $display("test scroll done");
      wr(8'h95, 8'hC0);
      foreach (mem[b, a]) mem[b][a] = 8'h00;
      note(2'h1, 120'h0, 8'h00);
      fetch(3, 0);
      idle(2);
      $display("test clear done");
      finish_test();
   end
endmodule
